//--- pkg/wdf_map.vh
/*
 * register map, field codes and timing constants of the watchdog and
 * fail-safe supervisor; assumes a 250 MHz system clock and a 100 us tick
 */
`ifndef WDF_MAP_VH
`define WDF_MAP_VH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define WDF_ADDR_SETUP_A 7'h13
`define WDF_ADDR_SETUP_B 7'h14
`define WDF_ADDR_SERVICE 7'h15
`define WDF_ADDR_PULSE 7'h16
`define WDF_ADDR_FS 7'h17
`define WDF_ADDR_FS_TALLY 7'h18

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define WDF_RST_SETUP_A 8'h15
`define WDF_RST_TIMER 3'h0
`define WDF_RST_TALLY 4'h1
`define WDF_RST_PULSE 4'h7
`define WDF_RST_FS 8'h00
`define WDF_RST_FS_TALLY 8'h00

// ----------------------------------------------------------------
// field codes
// ----------------------------------------------------------------
`define WDF_MODE_OFF 2'h0
`define WDF_MODE_TIMEOUT 2'h1
`define WDF_MODE_WINDOW 2'h2
`define WDF_MODE_QA 2'h3
`define WDF_ACT_PWR 2'h0
`define WDF_ACT_IRQ 2'h1
`define WDF_ACT_STBY 2'h2
`define WDF_ACT_RSVD 2'h3
`define WDF_THR_0 4'h1
`define WDF_THR_1 4'h5
`define WDF_THR_2 4'h9
`define WDF_THR_3 4'hf
`define WDF_TALLY_MAX 4'hf
`define WDF_SERVICE_KEY 8'hff
`define WDF_IRQ_SEL_WD 2'h1
`define WDF_FS_NONE 3'h0
`define WDF_FS_PWR 3'h1
`define WDF_FS_SOFT 3'h2
`define WDF_FS_POR 3'h3
`define WDF_FS_SLEEP 3'h4
`define WDF_CAUSE_NONE 3'h0
`define WDF_CAUSE_THERM 3'h1
`define WDF_CAUSE_UV 3'h3

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define WDF_TIMER_HI 7
`define WDF_TIMER_LO 5
`define WDF_PW_HI 3
`define WDF_PW_LO 0
`define WDF_FS_EN_BIT 7
`define WDF_FS_ACT_HI 6
`define WDF_FS_ACT_LO 4
`define WDF_FS_OFF_BIT 0
`define WDF_LIMIT_HI 7
`define WDF_LIMIT_LO 4
`define WDF_FS_TALLY_HI 3
`define WDF_FS_TALLY_LO 0

// ----------------------------------------------------------------
// spi frame
// ----------------------------------------------------------------
`define WDF_SPI_WR_BIT 7
`define WDF_SPI_CMD_LAST 5'h07
`define WDF_SPI_FRAME_LAST 5'h0f
`define WDF_SPI_FRAME_END 5'h10

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define WDF_CLK_NS 4
`define WDF_NS_PER_MS 1000000
`define WDF_NS_PER_US 1000
`define WDF_TICK_NS 100000
`define WDF_WD_OFF_MS 300
`define WDF_FS_OFF_MS 1000
`define WDF_PW1_US 3600
`define WDF_PW2_US 10000
`define WDF_PW4_US 40000
`define WDF_PW7_US 150000
`define WDF_PW8_US 1000
`define WDF_PWB_US 20000
`define WDF_PWD_US 60000
`define WDF_PWE_US 100000
`define WDF_PERIOD_MS_TABLE {16'd4096, 16'd2048, 16'd1024, 16'd512, 16'd256, 16'd128, \
	16'd32, 16'd4}

`endif

//--- rtl/wdf_spi_port.v
/*
 * spi register port: mode 0, msb first, 16-bit frame of command byte
 * (bit 7 set for write, bits 6:0 address) then data byte; read data is
 * shifted out during the data byte. assumes sclk far slower than sys_clk.
 */
`timescale 1ns/1ns
`default_nettype none
`include "wdf_map.vh"

module wdf_spi_port (
	input wire sys_clk,
	input wire reset,
	input wire spi_sclk,
	input wire spi_cs_n,
	input wire spi_mosi,
	input wire [7:0] rd_data,
	output reg [6:0] bus_addr,
	output reg [7:0] bus_wdata,
	output reg bus_wr,
	output reg spi_miso,
	output reg spi_miso_oe
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	reg sclk_s1_q, sclk_s2_q, sclk_s3_q;
	reg cs_s1_q, cs_s2_q, mosi_s1_q, mosi_s2_q;
	reg [4:0] bit_cnt_q;
	reg [7:0] rx_q, tx_q;
	reg is_wr_q, load_q;
	wire rise = sclk_s2_q & ~sclk_s3_q;
	wire fall = ~sclk_s2_q & sclk_s3_q;
	wire [7:0] rx_next = {rx_q[6:0], mosi_s2_q};

	always @(posedge sys_clk) begin
		if (reset) begin
			sclk_s1_q <= 1'b0;
			sclk_s2_q <= 1'b0;
			sclk_s3_q <= 1'b0;
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			mosi_s1_q <= 1'b0;
			mosi_s2_q <= 1'b0;
		end else begin
			sclk_s1_q <= spi_sclk;
			sclk_s2_q <= sclk_s1_q;
			sclk_s3_q <= sclk_s2_q;
			cs_s1_q <= spi_cs_n;
			cs_s2_q <= cs_s1_q;
			mosi_s1_q <= spi_mosi;
			mosi_s2_q <= mosi_s1_q;
		end
	end

	// ----------------------------------------------------------------
	// frame engine
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (reset) begin
			bit_cnt_q <= 5'h00;
			rx_q <= 8'h00;
			tx_q <= 8'h00;
			is_wr_q <= 1'b0;
			load_q <= 1'b0;
			bus_addr <= 7'h00;
			bus_wdata <= 8'h00;
			bus_wr <= 1'b0;
			spi_miso <= 1'b0;
			spi_miso_oe <= 1'b0;
		end else begin
			bus_wr <= 1'b0;
			load_q <= 1'b0;
			if (cs_s2_q) begin
				bit_cnt_q <= 5'h00;
				spi_miso_oe <= 1'b0;
				spi_miso <= 1'b0;
				tx_q <= 8'h00;
			end else begin
				spi_miso_oe <= 1'b1;
				if (load_q)
					tx_q <= rd_data;
				if (rise && bit_cnt_q != `WDF_SPI_FRAME_END) begin
					rx_q <= rx_next;
					bit_cnt_q <= bit_cnt_q + 5'h01;
					if (bit_cnt_q == `WDF_SPI_CMD_LAST) begin
						bus_addr <= rx_next[6:0];
						is_wr_q <= rx_next[`WDF_SPI_WR_BIT];
						load_q <= 1'b1;
					end
					if (bit_cnt_q == `WDF_SPI_FRAME_LAST && is_wr_q) begin
						bus_wdata <= rx_next;
						bus_wr <= 1'b1;
					end
				end
				if (fall) begin
					spi_miso <= tx_q[7];
					tx_q <= {tx_q[6:0], 1'b0};
				end
			end
		end
	end

endmodule

`default_nettype wire

//--- rtl/wdf_supervisor.v
/*
 * watchdog and fail-safe supervisor with its spi register port.
 * assumes fail-safe entry pulses and the irq clear pulse come from logic
 * on sys_clk; the irq pin select and serial-out option arrive as levels.
 */
// Operation
// - mode field: off, timeout, window, question/answer
// - prescaler scales period by one to four
// - threshold: trigger at 1, 5, 9, 15 errors
// - action: power off 300ms, irq, standby
// - irq pin pulses low under three settings
// - timer field selects period with prescaler
// - read-only error tally cleared to zero when threshold reached
// - ff write restarts timer, also in closed half
// - pulse width field selects irq pulse length
// - enable bit gates fail-safe entry counting
// - over-limit action: none, power 1s, resets
// - sleep lock ignores wake until power cycle
// - wake timer starts after fail-safe power action ends
// - cause field: none, thermal, undervoltage
// - cause held until tally written zero
// - bit zero disables power-up fail-safe
// - limit holds entries allowed before action
// - select 01 routes watchdog failure to pin
`timescale 1ns/1ns
`default_nettype none
`include "wdf_map.vh"

module wdf_supervisor #(
	parameter TICK_CYC = `WDF_TICK_NS / `WDF_CLK_NS,
	parameter [127:0] PERIOD_MS = `WDF_PERIOD_MS_TABLE
) (
	input wire sys_clk,
	input wire reset,
	input wire spi_sclk,
	input wire spi_cs_n,
	input wire spi_mosi,
	output wire spi_miso,
	output wire spi_miso_oe,
	input wire [1:0] irq_pin_source_select,
	input wire serial_out_pin_option,
	input wire selective_wake_enable,
	input wire fs_enter_thermal,
	input wire fs_enter_uv,
	input wire wd_irq_clear,
	output reg wd_irq_flag,
	output reg irq_pin_low_active,
	output reg node_power_switch_pin,
	output reg standby_req,
	output reg soft_reset_req,
	output reg por_req,
	output reg wake_ignore,
	output reg selective_wake_timer_start,
	output wire powerup_safe_state_off
);

	// ----------------------------------------------------------------
	// time conversion
	// ----------------------------------------------------------------
	localparam TICKS_PER_MS = `WDF_NS_PER_MS / `WDF_TICK_NS;
	localparam [31:0] WD_OFF_WIDE = `WDF_WD_OFF_MS * TICKS_PER_MS;
	localparam [31:0] FS_OFF_WIDE = `WDF_FS_OFF_MS * TICKS_PER_MS;
	localparam [31:0] TICK_LAST_WIDE = TICK_CYC - 1;
	localparam [13:0] WD_OFF_TICKS = WD_OFF_WIDE[13:0];
	localparam [13:0] FS_OFF_TICKS = FS_OFF_WIDE[13:0];
	localparam [19:0] TICK_LAST = TICK_LAST_WIDE[19:0];

	function [13:0] us_ticks;
		input [31:0] us;
		reg [31:0] t;
		begin
			t = (us * `WDF_NS_PER_US + `WDF_TICK_NS - 1) / `WDF_TICK_NS;
			us_ticks = t[13:0];
		end
	endfunction

	function [13:0] pulse_ticks;
		input [3:0] code;
		begin
			case (code)
			4'h1: pulse_ticks = us_ticks(`WDF_PW1_US);
			4'h2: pulse_ticks = us_ticks(`WDF_PW2_US);
			4'h4: pulse_ticks = us_ticks(`WDF_PW4_US);
			4'h8: pulse_ticks = us_ticks(`WDF_PW8_US);
			4'hb: pulse_ticks = us_ticks(`WDF_PWB_US);
			4'hd: pulse_ticks = us_ticks(`WDF_PWD_US);
			4'he: pulse_ticks = us_ticks(`WDF_PWE_US);
			default: pulse_ticks = us_ticks(`WDF_PW7_US);
			endcase
		end
	endfunction

	function [19:0] period_ticks;
		input [2:0] sel;
		input [1:0] pre;
		reg [31:0] t;
		begin
			t = PERIOD_MS[sel * 16 +: 16] * TICKS_PER_MS * (pre + 1);
			period_ticks = t[19:0];
		end
	endfunction

	// ----------------------------------------------------------------
	// registers and bus
	// ----------------------------------------------------------------
	reg [1:0] mode_q, scale_q, thr_sel_q, act_q;
	reg [2:0] timer_q, fs_act_q, cause_q;
	reg [3:0] tally_q, pulse_q, fs_limit_q, fs_tally_q;
	reg fs_en_q, fs_off_q;
	reg [19:0] tick_cnt_q, wd_cnt_q;
	reg [13:0] pwr_cnt_q, pls_cnt_q;
	reg pwr_fs_q;
	reg [7:0] rd_data;
	reg [3:0] thr;
	wire [6:0] bus_addr;
	wire [7:0] bus_wdata;
	wire bus_wr;

	// ----------------------------------------------------------------
	// write field decode
	// ----------------------------------------------------------------
	wire [2:0] wr_timer = bus_wdata[`WDF_TIMER_HI:`WDF_TIMER_LO];
	wire [3:0] wr_pulse = bus_wdata[`WDF_PW_HI:`WDF_PW_LO];
	wire wr_fs_en = bus_wdata[`WDF_FS_EN_BIT];
	wire [2:0] wr_fs_act = bus_wdata[`WDF_FS_ACT_HI:`WDF_FS_ACT_LO];
	wire wr_fs_off = bus_wdata[`WDF_FS_OFF_BIT];
	wire [3:0] wr_limit = bus_wdata[`WDF_LIMIT_HI:`WDF_LIMIT_LO];
	wire [3:0] wr_tally = bus_wdata[`WDF_FS_TALLY_HI:`WDF_FS_TALLY_LO];

	wdf_spi_port u_spi (
		.sys_clk(sys_clk),
		.reset(reset),
		.spi_sclk(spi_sclk),
		.spi_cs_n(spi_cs_n),
		.spi_mosi(spi_mosi),
		.rd_data(rd_data),
		.bus_addr(bus_addr),
		.bus_wdata(bus_wdata),
		.bus_wr(bus_wr),
		.spi_miso(spi_miso),
		.spi_miso_oe(spi_miso_oe)
	);

	assign powerup_safe_state_off = fs_off_q;

	always @* begin
		case (bus_addr)
		`WDF_ADDR_SETUP_A: rd_data = {mode_q, scale_q, thr_sel_q, act_q};
		`WDF_ADDR_SETUP_B: rd_data = {timer_q, tally_q, 1'b0};
		`WDF_ADDR_PULSE: rd_data = {4'h0, pulse_q};
		`WDF_ADDR_FS: rd_data = {fs_en_q, fs_act_q, cause_q, fs_off_q};
		`WDF_ADDR_FS_TALLY: rd_data = {fs_limit_q, fs_tally_q};
		default: rd_data = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// watchdog timing
	// ----------------------------------------------------------------
	wire tick = (tick_cnt_q == TICK_LAST);
	wire [19:0] period = period_ticks(timer_q, scale_q);
	wire wd_on = (mode_q != `WDF_MODE_OFF);
	wire closed_half = (mode_q == `WDF_MODE_WINDOW || mode_q == `WDF_MODE_QA) &&
		(wd_cnt_q < {1'b0, period[19:1]});
	wire svc_wr = bus_wr && bus_addr == `WDF_ADDR_SERVICE && bus_wdata == `WDF_SERVICE_KEY;
	wire svc_bad = wd_on && svc_wr && closed_half;
	wire expire = wd_on && !svc_wr && tick && (wd_cnt_q + 20'h1 >= period);
	wire wd_err = svc_bad | expire;
	wire [3:0] tally_inc = (tally_q == `WDF_TALLY_MAX) ? tally_q : tally_q + 4'h1;

	always @* begin
		case (thr_sel_q)
		2'h0: thr = `WDF_THR_0;
		2'h1: thr = `WDF_THR_1;
		2'h2: thr = `WDF_THR_2;
		default: thr = `WDF_THR_3;
		endcase
	end

	wire wd_trig = wd_err && (tally_inc >= thr);
	wire pulse_mode = (act_q == `WDF_ACT_IRQ) && serial_out_pin_option &&
		(irq_pin_source_select == `WDF_IRQ_SEL_WD);

	// ----------------------------------------------------------------
	// fail-safe counting
	// ----------------------------------------------------------------
	wire fs_entry = fs_enter_thermal | fs_enter_uv;
	wire [3:0] fs_inc = (fs_tally_q == `WDF_TALLY_MAX) ? fs_tally_q : fs_tally_q + 4'h1;
	wire fs_count = fs_entry && fs_en_q;
	wire fs_fire = fs_count && (fs_inc > fs_limit_q);
	wire tally_clr = bus_wr && bus_addr == `WDF_ADDR_FS_TALLY && wr_tally == 4'h0;

	always @(posedge sys_clk) begin
		if (reset) begin
			{mode_q, scale_q, thr_sel_q, act_q} <= `WDF_RST_SETUP_A;
			timer_q <= `WDF_RST_TIMER;
			tally_q <= `WDF_RST_TALLY;
			pulse_q <= `WDF_RST_PULSE;
			{fs_en_q, fs_act_q, cause_q, fs_off_q} <= `WDF_RST_FS;
			{fs_limit_q, fs_tally_q} <= `WDF_RST_FS_TALLY;
			tick_cnt_q <= 20'h0;
			wd_cnt_q <= 20'h0;
		end else begin
			tick_cnt_q <= tick ? 20'h0 : tick_cnt_q + 20'h1;
			if (bus_wr) begin
				case (bus_addr)
				`WDF_ADDR_SETUP_A: {mode_q, scale_q, thr_sel_q, act_q} <= bus_wdata;
				`WDF_ADDR_SETUP_B: timer_q <= wr_timer;
				`WDF_ADDR_PULSE: pulse_q <= wr_pulse;
				`WDF_ADDR_FS: begin
					fs_en_q <= wr_fs_en;
					fs_act_q <= wr_fs_act;
					fs_off_q <= wr_fs_off;
				end
				`WDF_ADDR_FS_TALLY: fs_limit_q <= wr_limit;
				default: begin
				end
				endcase
			end
			if (!wd_on || svc_wr || expire)
				wd_cnt_q <= 20'h0;
			else if (tick)
				wd_cnt_q <= wd_cnt_q + 20'h1;
			if (wd_trig)
				tally_q <= 4'h0;
			else if (wd_err)
				tally_q <= tally_inc;
			if (fs_count)
				fs_tally_q <= fs_inc;
			else if (tally_clr)
				fs_tally_q <= 4'h0;
			if (fs_enter_thermal)
				cause_q <= `WDF_CAUSE_THERM;
			else if (fs_enter_uv)
				cause_q <= `WDF_CAUSE_UV;
			else if (tally_clr)
				cause_q <= `WDF_CAUSE_NONE;
		end
	end

	// ----------------------------------------------------------------
	// output actions
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (reset) begin
			pwr_cnt_q <= 14'h0;
			pwr_fs_q <= 1'b0;
			pls_cnt_q <= 14'h0;
			wd_irq_flag <= 1'b0;
			irq_pin_low_active <= 1'b1;
			node_power_switch_pin <= 1'b1;
			standby_req <= 1'b0;
			soft_reset_req <= 1'b0;
			por_req <= 1'b0;
			wake_ignore <= 1'b0;
			selective_wake_timer_start <= 1'b0;
		end else begin
			standby_req <= 1'b0;
			soft_reset_req <= 1'b0;
			por_req <= 1'b0;
			selective_wake_timer_start <= 1'b0;
			if (wd_trig && act_q != `WDF_ACT_RSVD)
				wd_irq_flag <= 1'b1;
			else if (wd_irq_clear)
				wd_irq_flag <= 1'b0;
			if (fs_fire && fs_act_q == `WDF_FS_PWR) begin
				pwr_cnt_q <= FS_OFF_TICKS;
				pwr_fs_q <= 1'b1;
			end else if (wd_trig && (act_q == `WDF_ACT_PWR || act_q == `WDF_ACT_STBY)) begin
				pwr_cnt_q <= WD_OFF_TICKS;
				pwr_fs_q <= 1'b0;
			end else if (tick && pwr_cnt_q != 14'h0) begin
				pwr_cnt_q <= pwr_cnt_q - 14'h1;
				if (pwr_cnt_q == 14'h1 && pwr_fs_q)
					selective_wake_timer_start <= selective_wake_enable;
			end
			node_power_switch_pin <= (pwr_cnt_q == 14'h0);
			if (wd_trig && act_q == `WDF_ACT_STBY)
				standby_req <= 1'b1;
			if (fs_fire && fs_act_q == `WDF_FS_SOFT)
				soft_reset_req <= 1'b1;
			if (fs_fire && fs_act_q == `WDF_FS_POR)
				por_req <= 1'b1;
			if (fs_fire && fs_act_q == `WDF_FS_SLEEP)
				wake_ignore <= 1'b1;
			if (wd_trig && pulse_mode)
				pls_cnt_q <= pulse_ticks(pulse_q);
			else if (tick && pls_cnt_q != 14'h0)
				pls_cnt_q <= pls_cnt_q - 14'h1;
			if (irq_pin_source_select != `WDF_IRQ_SEL_WD)
				irq_pin_low_active <= 1'b1;
			else if (pulse_mode)
				irq_pin_low_active <= (pls_cnt_q == 14'h0);
			else
				irq_pin_low_active <= ~wd_irq_flag;
		end
	end

endmodule

`default_nettype wire

//--- tb/wdf_sva.sv
/*
 * checker for wdf_supervisor output behaviour
 * assumes one clock domain and the synchronous reset
 */
`timescale 1ns/1ns
`default_nettype none
module wdf_sva (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [1:0] irq_pin_source_select,
	input wire logic serial_out_pin_option,
	input wire logic selective_wake_enable,
	input wire logic wd_irq_clear,
	input wire logic wd_irq_flag,
	input wire logic irq_pin_low_active,
	input wire logic node_power_switch_pin,
	input wire logic standby_req,
	input wire logic soft_reset_req,
	input wire logic por_req,
	input wire logic wake_ignore,
	input wire logic selective_wake_timer_start
);
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	AST_FLAG_HOLD: assert property (wd_irq_flag && !wd_irq_clear |=> wd_irq_flag)
		else $error("irq flag dropped without clear");
	AST_PWR_LOW: assert property ($fell(node_power_switch_pin) |-> !node_power_switch_pin[*8])
		else $error("power pin off too briefly");
	AST_STBY_PWR: assert property (standby_req |-> ##[0:2] !node_power_switch_pin)
		else $error("standby without power off");
	AST_PIN_FLAG: assert property ((irq_pin_source_select == 2'h1 && !serial_out_pin_option)[*2]
		|-> irq_pin_low_active == !$past(wd_irq_flag)) else $error("pin not showing flag");
	AST_SR_PULSE: assert property (soft_reset_req |=> !soft_reset_req)
		else $error("soft reset request too long");
	AST_POR_PULSE: assert property (por_req |=> !por_req[*2])
		else $error("por request too long");
	AST_WAKE_STICKY: assert property ($fell(wake_ignore) |-> 1'b0)
		else $error("wake ignore released");
	AST_SWE_GATE: assert property (selective_wake_timer_start |-> $past(selective_wake_enable))
		else $error("wake timer started while disabled");
	COV_STBY: cover property (standby_req);
	COV_PULSE: cover property ($fell(irq_pin_low_active));
	COV_POR: cover property (por_req);
endmodule
bind wdf_supervisor wdf_sva wdf_sva_i (.sys_clk, .reset, .irq_pin_source_select,
	.serial_out_pin_option, .selective_wake_enable, .wd_irq_clear, .wd_irq_flag,
	.irq_pin_low_active, .node_power_switch_pin, .standby_req, .soft_reset_req, .por_req,
	.wake_ignore, .selective_wake_timer_start);
`default_nettype wire

//--- tb/wdf_host.sv
/*
 * host model: spi master, mode 0, 16-bit frames
 * assumes sys_clk at 250 MHz; sclk half period is 8 cycles
 */
`timescale 1ns/1ns
`default_nettype none
module wdf_host (
	input wire logic sys_clk,
	input wire logic spi_miso,
	output logic spi_sclk,
	output logic spi_cs_n,
	output logic spi_mosi
);
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end
	// ----------------------------------------------------------------
	// one frame: command byte then data byte, msb first
	// ----------------------------------------------------------------
	task automatic xfer(input logic [15:0] f, output logic [7:0] rd);
		rd = 8'h00;
		@(negedge sys_clk);
		spi_cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			spi_mosi = f[i];
			repeat (8) @(negedge sys_clk);
			spi_sclk = 1'b1;
			rd = {rd[6:0], spi_miso};
			repeat (8) @(negedge sys_clk);
			spi_sclk = 1'b0;
		end
		repeat (8) @(negedge sys_clk);
		spi_cs_n = 1'b1;
		spi_mosi = ~spi_mosi;
		repeat (8) @(negedge sys_clk);
	endtask
endmodule
`default_nettype wire

//--- tb/tb_wdf_supervisor.sv
/*
 * testbench for wdf_supervisor with shortened tick and period table
 * assumes the host model for all register access
 */
`timescale 1ns/1ns
`default_nettype none
module tb_wdf_supervisor;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
	logic [1:0] sel = 2'h0;
	logic opt = 1'b0;
	logic selective_wake_timer = 1'b0;
	logic fs_t = 1'b0;
	logic fs_u = 1'b0;
	logic clr = 1'b0;
	logic flag, pin, pwr, stby, srr, por, wig, swst, pso;
	logic [7:0] rd;
	int fail_count = 0;
	int tests_run = 0;
	int n_sr = 0;
	int n_por = 0;
	int n_stby = 0;
	int n_swe = 0;
	int n;
	always #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		n_sr <= n_sr + (srr === 1'b1);
		n_por <= n_por + (por === 1'b1);
		n_stby <= n_stby + (stby === 1'b1);
		n_swe <= n_swe + (swst === 1'b1);
	end
	wdf_supervisor #(.TICK_CYC(10), .PERIOD_MS({8{16'h0008}})) wdf_supervisor_i (
		.sys_clk, .reset, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe,
		.irq_pin_source_select(sel), .serial_out_pin_option(opt),
		.selective_wake_enable(selective_wake_timer), .fs_enter_thermal(fs_t), .fs_enter_uv(fs_u),
		.wd_irq_clear(clr), .wd_irq_flag(flag), .irq_pin_low_active(pin),
		.node_power_switch_pin(pwr), .standby_req(stby), .soft_reset_req(srr),
		.por_req(por), .wake_ignore(wig), .selective_wake_timer_start(swst),
		.powerup_safe_state_off(pso));
	wdf_host wdf_host_i (.sys_clk, .spi_miso, .spi_sclk, .spi_cs_n, .spi_mosi);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic tick(input int c);
		repeat (c) @(negedge sys_clk);
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		tests_run++;
		if (s !== e) begin
			fail_count++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		wdf_host_i.xfer({1'b1, a, d}, rd);
	endtask
	task automatic rdc(input logic [6:0] a, input logic [7:0] e);
		wdf_host_i.xfer({1'b0, a, 8'h00}, rd);
		chk($sformatf("reg %h", a), e, rd);
	endtask
	task automatic pulse_clr;
		clr = 1'b1;
		tick(1);
		clr = 1'b0;
	endtask
	task automatic wait_flag(input int lim);
		for (n = 0; n < lim && flag !== 1'b1; n++) tick(1);
	endtask
	task automatic fs(input logic uv);
		fs_t = ~uv;
		fs_u = uv;
		tick(1);
		fs_t = 1'b0;
		fs_u = 1'b0;
		tick(4);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		chk("miso oe idle", 8'h00, 8'(spi_miso_oe));
		rdc(7'h13, 8'h15);
		rdc(7'h14, 8'h02);
		wr(7'h14, 8'hff);
		rdc(7'h14, 8'he2);
		rdc(7'h15, 8'h00);
		rdc(7'h16, 8'h07);
		rdc(7'h17, 8'h00);
		rdc(7'h20, 8'h00);
	endtask
	task automatic t_timeout;
		wr(7'h15, 8'hff);
		wr(7'h13, 8'h41);
		pulse_clr;
		repeat (3) wr(7'h15, 8'hff);
		chk("serviced flag", 8'h00, 8'(flag));
		wait_flag(1000);
		chk("expiry flag", 8'h01, 8'(flag));
		rdc(7'h14, 8'he0);
		wr(7'h13, 8'h71);
		wr(7'h15, 8'hff);
		pulse_clr;
		wait_flag(4000);
		chk("scaled period", 8'h01, 8'(n > 3000 && n < 3250));
	endtask
	task automatic t_window;
		wr(7'h13, 8'h81);
		pulse_clr;
		wait_flag(1000);
		pulse_clr;
		wr(7'h15, 8'hff);
		wait_flag(300);
		chk("early service", 8'h01, 8'(flag));
		pulse_clr;
		tick(450);
		wr(7'h15, 8'hff);
		chk("open service", 8'h00, 8'(flag));
		wr(7'h13, 8'hc1);
		wr(7'h15, 8'hff);
		wr(7'h15, 8'hff);
		chk("qa early service", 8'h01, 8'(flag));
		wr(7'h13, 8'h85);
		pulse_clr;
		repeat (5) wr(7'h15, 8'hff);
		chk("before fifth error", 8'h00, 8'(flag));
		wr(7'h15, 8'hff);
		chk("fifth error", 8'h01, 8'(flag));
	endtask
	task automatic t_power;
		wr(7'h13, 8'h42);
		for (n = 0; n < 1000 && pwr !== 1'b0; n++) tick(1);
		chk("power off", 8'h00, 8'(pwr));
		chk("standby", 8'h01, 8'(n_stby > 0));
		wr(7'h13, 8'h02);
		tick(25000);
		chk("power held", 8'h00, 8'(pwr));
		for (n = 0; n < 6000 && pwr !== 1'b1; n++) tick(1);
		chk("power back", 8'h01, 8'(pwr));
	endtask
	task automatic t_pulse;
		pulse_clr;
		sel = 2'h1;
		opt = 1'b1;
		wr(7'h16, 8'h08);
		wr(7'h13, 8'h41);
		for (n = 0; n < 1000 && pin !== 1'b0; n++) tick(1);
		for (n = 0; n < 200 && pin === 1'b0; n++) tick(1);
		chk("pulse width", 8'h01, 8'(n > 90 && n < 111));
		opt = 1'b0;
		wr(7'h13, 8'h01);
		chk("pin shows flag", 8'h00, 8'(pin));
		pulse_clr;
		tick(2);
		chk("pin idle", 8'h01, 8'(pin));
	endtask
	task automatic t_fail;
		wr(7'h18, 8'h00);
		wr(7'h17, 8'h20);
		fs(1'b0);
		chk("count off", 8'h00, 8'(n_sr));
		wr(7'h17, 8'ha0);
		fs(1'b0);
		rdc(7'h17, 8'ha2);
		rdc(7'h18, 8'h01);
		fs(1'b1);
		rdc(7'h17, 8'ha6);
		chk("soft reset", 8'h02, 8'(n_sr));
		wr(7'h18, 8'h00);
		rdc(7'h17, 8'ha0);
		wr(7'h18, 8'h10);
		wr(7'h17, 8'hb1);
		fs(1'b0);
		chk("below limit", 8'h00, 8'(n_por));
		fs(1'b0);
		chk("por", 8'h01, 8'(n_por));
		chk("safe state off", 8'h01, 8'(pso));
		selective_wake_timer = 1'b1;
		wr(7'h17, 8'hc0);
		fs(1'b0);
		chk("sleep lock", 8'h01, 8'(wig));
		wr(7'h17, 8'h90);
		fs(1'b0);
		chk("fs power off", 8'h00, 8'(pwr));
		tick(200);
		chk("wake start waits", 8'h00, 8'(n_swe));
	endtask
	// ----------------------------------------------------------------
	// main sequence and watchdog (tests take about 49000 cycles)
	// ----------------------------------------------------------------
	initial begin
		tick(6);
		reset = 1'b0;
		tick(6);
		t_reset;
		t_timeout;
		t_window;
		t_power;
		t_pulse;
		t_fail;
		stop_test;
	end
	initial begin
		tick(95000);
		fail_count++;
		stop_test;
	end
endmodule
`default_nettype wire
